// File: src/tac_pkg.sv
// Constants for the timer access contention channel.
// Assumes a 16-bit register port with word indices and byte enables.
package tac_pkg;
  // Widths
  localparam int CNT_W_DEF = 16;
  localparam int ADDR_W    = 4;
  // Register word indices
  localparam logic [3:0] OFS_CONTROL  = 4'h0;
  localparam logic [3:0] OFS_IO       = 4'h1;
  localparam logic [3:0] OFS_COUNT    = 4'h2;
  localparam logic [3:0] OFS_GR_A     = 4'h3;
  localparam logic [3:0] OFS_GR_B     = 4'h4;
  localparam logic [3:0] OFS_BUF_A    = 4'h5;
  localparam logic [3:0] OFS_BUF_B    = 4'h6;
  localparam logic [3:0] OFS_STATUS   = 4'h7;
  localparam logic [3:0] OFS_MASK     = 4'h8;
  localparam logic [3:0] OFS_MODE     = 4'h9;
  localparam logic [3:0] OFS_FUNC     = 4'hA;
  // Field positions
  localparam int CTL_CLK_LSB   = 0;
  localparam int CTL_CLR_LSB   = 5;
  localparam int IO_B_LSB      = 4;
  localparam int IO_FUNC_BIT   = 2;
  localparam int MODE_RUN_BIT  = 0;
  localparam int MODE_SYNC_BIT = 1;
  localparam int FUNC_BUF_LSB  = 0;
  localparam int FUNC_LO_BIT   = 4;
  localparam int FUNC_HI_BIT   = 5;
  localparam int ST_WRAP_BIT   = 2;
  // Clear source encodings
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A    = 2'h1;
  localparam logic [1:0] CLR_B    = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  // Reset values
  localparam logic [15:0] RST_REG   = 16'h0000;
  localparam logic [15:0] RST_GR    = 16'hFFFF;
  localparam logic [2:0]  RST_FLAGS = 3'h0;
endpackage

// File: src/tac_channel.sv
// One 16-bit timer channel with bus/event contention arbitration.
// Assumes a single-cycle register port and asynchronous pins.
`timescale 1ns/1ns

module tac_channel
  import tac_pkg::*;
#(
  parameter int CNT_W = CNT_W_DEF
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [15:0]       bus_wdata,
  input  wire logic [1:0]        bus_byte_en,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [15:0]       bus_rdata,
  // Pins
  input  wire logic              ext_clk_pin,
  input  wire logic              cap_a_pin,
  input  wire logic              cap_b_pin,
  output logic                   out_a,
  output logic                   out_b,
  // Synchronized peers
  input  wire logic              sync_clear_in,
  input  wire logic              sync_preset_in,
  input  wire logic [15:0]       sync_preset_value,
  output logic                   sync_clear_out,
  output logic                   sync_preset_out,
  output logic      [15:0]       sync_preset_data,
  // Interrupt
  output logic                   irq
);

  if (CNT_W != 16) begin : g_bad_width
    $error("tac_channel: byte lanes need CNT_W of 16");
  end

  // Registers
  logic [15:0]      channel0_control;
  logic [15:0]      channel0_io_control;
  logic [15:0]      timer_mode_reg;
  logic [15:0]      function_control_reg;
  logic [CNT_W-1:0] timer_count_value;
  logic [CNT_W-1:0] gen_reg [2];
  logic [CNT_W-1:0] buf_reg [2];
  logic [2:0]       status;
  logic [2:0]       read_armed;
  logic [2:0]       int_mask;
  // T3 stage of a write
  logic              pend_valid;
  logic [ADDR_W-1:0] pend_addr;
  logic [15:0]       pend_data;
  logic [1:0]        pend_be;
  // Pin synchronisers: ext clock, capture A, capture B
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;
  logic [2:0] prescale;

  function automatic logic [15:0] merge_bytes(input logic [15:0] old,
                                              input logic [15:0] data,
                                              input logic [1:0]  be);
    merge_bytes = {be[1] ? data[15:8] : old[15:8],
                   be[0] ? data[7:0]  : old[7:0]};
  endfunction

  function automatic logic cap_edge(input logic [1:0] sel,
                                    input logic       prev,
                                    input logic       cur);
    cap_edge = (sel[0] && !prev && cur) || (sel[1] && prev && !cur);
  endfunction

  function automatic logic pin_action(input logic [1:0] sel,
                                      input logic       cur);
    case (sel)
      2'h1:    pin_action = 1'b0;
      2'h2:    pin_action = 1'b1;
      2'h3:    pin_action = !cur;
      default: pin_action = cur;
    endcase
  endfunction

  // Decoded controls
  logic [2:0] clk_sel;
  logic [1:0] clear_sel;
  logic       run;
  logic       channel0_sync_select;
  logic [1:0] buffer_on;
  logic       combo_mode_select_hi;
  logic       combo_mode_select_lo;
  logic [2:0] io_sel [2];
  logic       is_capture [2];

  assign clk_sel              = channel0_control[CTL_CLK_LSB +: 3];
  assign clear_sel            = channel0_control[CTL_CLR_LSB +: 2];
  assign run                  = timer_mode_reg[MODE_RUN_BIT];
  assign channel0_sync_select = timer_mode_reg[MODE_SYNC_BIT];
  assign buffer_on            = function_control_reg[FUNC_BUF_LSB +: 2];
  assign combo_mode_select_hi = function_control_reg[FUNC_HI_BIT];
  assign combo_mode_select_lo = function_control_reg[FUNC_LO_BIT];
  assign io_sel[0]            = channel0_io_control[2:0];
  assign io_sel[1]            = channel0_io_control[IO_B_LSB +: 3];
  assign is_capture[0]        = io_sel[0][IO_FUNC_BIT];
  assign is_capture[1]        = io_sel[1][IO_FUNC_BIT];

  // Timer events
  logic       tick;
  logic       inc;
  logic [1:0] match;
  logic [1:0] capture;
  logic [1:0] gr_wr_t3;
  logic [1:0] buf_wr_t3;
  logic       cnt_wr_t3;
  logic       cnt_byte_t2;
  logic       local_clear;
  logic       clear_evt;
  logic       wrap_evt;
  logic [15:0] cnt_wr_value;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    case (clk_sel)
      3'h0:    tick = 1'b1;
      3'h1:    tick = prescale[0];
      3'h2:    tick = &prescale[1:0];
      3'h3:    tick = &prescale;
      default: tick = pin_sync[0] && !pin_prev[0];
    endcase
  end

  assign inc         = run && tick;
  assign cnt_wr_t3   = pend_valid && pend_addr == OFS_COUNT;
  assign cnt_byte_t2 = bus_wr && bus_addr == OFS_COUNT
                       && bus_byte_en != 2'h3;
  assign cnt_wr_value = merge_bytes(timer_count_value, pend_data, pend_be);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      gr_wr_t3[i]  = pend_valid && pend_addr == OFS_GR_A + 4'(i);
      buf_wr_t3[i] = pend_valid && pend_addr == OFS_BUF_A + 4'(i);
      // Fires on the step away from the match value
      match[i]   = inc && !is_capture[i] && !gr_wr_t3[i]
                   && timer_count_value == gen_reg[i];
      capture[i] = is_capture[i] && cap_edge(io_sel[i][1:0],
                   pin_prev[i+1], pin_sync[i+1]);
    end
  end

  always_comb begin
    case (clear_sel)
      CLR_A:   local_clear = match[0] || capture[0];
      CLR_B:   local_clear = match[1] || capture[1];
      default: local_clear = 1'b0;
    endcase
  end

  assign clear_evt = local_clear
                     || (clear_sel == CLR_SYNC && sync_clear_in);

  // Priority: clear, then T3 write, then peer preset, then increment
  always_comb begin
    next_count = timer_count_value;
    // A byte write in T2 swallows the step, so no wrap either, unless a T3 counter write falls in the same cycle
    wrap_evt   = inc && !clear_evt && (cnt_wr_t3 || !cnt_byte_t2)
                 && &timer_count_value;
    if (clear_evt) begin
      next_count = '0;
    end else if (cnt_wr_t3) begin
      next_count = cnt_wr_value;
    end else if (sync_preset_in && channel0_sync_select) begin
      next_count = sync_preset_value;
    end else if (inc && !cnt_byte_t2) begin
      next_count = timer_count_value + 1'b1;
    end
  end

  // Two-flop pin synchronisers plus an edge-detect flop; only the second stage and the edge-detect flop are read
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      pin_meta <= {cap_b_pin, cap_a_pin, ext_clk_pin};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prescale <= 3'h0;
    end else begin
      prescale <= prescale + 3'h1;
    end
  end

  // Strobe cycle is T2; the write lands at the end of T3
  always_ff @(posedge clock) begin
    if (rst) begin
      pend_valid <= 1'b0;
      pend_addr  <= '0;
      pend_data  <= RST_REG;
      pend_be    <= 2'h0;
    end else begin
      pend_valid <= bus_wr;
      pend_addr  <= bus_addr;
      pend_data  <= bus_wdata;
      pend_be    <= bus_byte_en;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      timer_count_value <= '0;
    end else begin
      timer_count_value <= next_count;
    end
  end

  // Capture wins over a T3 write; compare buffer loads on match
  always_ff @(posedge clock) begin
    if (rst) begin
      gen_reg[0] <= RST_GR;
      gen_reg[1] <= RST_GR;
      buf_reg[0] <= RST_GR;
      buf_reg[1] <= RST_GR;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (capture[i]) begin
          gen_reg[i] <= timer_count_value;
        end else if (gr_wr_t3[i]) begin
          gen_reg[i] <= merge_bytes(gen_reg[i], pend_data, pend_be);
        end else if (match[i] && buffer_on[i]) begin
          gen_reg[i] <= buf_reg[i];
        end
        if (capture[i] && buffer_on[i]) begin
          buf_reg[i] <= gen_reg[i];
        end else if (buf_wr_t3[i]) begin
          buf_reg[i] <= merge_bytes(buf_reg[i], pend_data, pend_be);
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      channel0_control     <= RST_REG;
      channel0_io_control  <= RST_REG;
      timer_mode_reg       <= RST_REG;
      function_control_reg <= RST_REG;
      int_mask             <= RST_FLAGS;
    end else if (pend_valid) begin
      case (pend_addr)
        OFS_CONTROL: channel0_control <=
          merge_bytes(channel0_control, pend_data, pend_be);
        OFS_IO: channel0_io_control <=
          merge_bytes(channel0_io_control, pend_data, pend_be);
        OFS_MODE: timer_mode_reg <=
          merge_bytes(timer_mode_reg, pend_data, pend_be);
        // Halting and mode order are left to software
        OFS_FUNC: function_control_reg <=
          merge_bytes(function_control_reg, pend_data, pend_be);
        OFS_MASK: int_mask <= pend_be[0] ? pend_data[2:0] : int_mask;
        default: int_mask <= int_mask;
      endcase
    end
  end

  // Flags: a set in the clearing cycle wins
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  always_comb begin
    flag_set = {wrap_evt, match[1] || capture[1], match[0] || capture[0]};
    flag_clr = 3'h0;
    if (pend_valid && pend_addr == OFS_STATUS && pend_be[0]) begin
      flag_clr = read_armed & ~pend_data[2:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status     <= RST_FLAGS;
      read_armed <= RST_FLAGS;
    end else begin
      status <= (status & ~flag_clr) | flag_set;
      if (bus_rd && bus_addr == OFS_STATUS) begin
        read_armed <= read_armed | status;
      end else if (pend_valid && pend_addr == OFS_STATUS) begin
        read_armed <= RST_FLAGS;
      end
    end
  end

  // Read data sampled in T2, so a capture in T3 is not seen
  logic [15:0] read_value;

  always_comb begin
    case (bus_addr)
      OFS_CONTROL: read_value = channel0_control;
      OFS_IO:      read_value = channel0_io_control;
      OFS_COUNT:   read_value = timer_count_value;
      OFS_GR_A:    read_value = gen_reg[0];
      OFS_GR_B:    read_value = gen_reg[1];
      OFS_BUF_A:   read_value = buf_reg[0];
      OFS_BUF_B:   read_value = buf_reg[1];
      OFS_STATUS:  read_value = {13'h0000, status};
      OFS_MASK:    read_value = {13'h0000, int_mask};
      OFS_MODE:    read_value = timer_mode_reg;
      OFS_FUNC:    read_value = function_control_reg;
      default:     read_value = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bus_rdata <= 16'h0000;
    end else begin
      bus_rdata <= bus_rd ? read_value : 16'h0000;
    end
  end

  // Pin outputs and interrupt
  always_ff @(posedge clock) begin
    if (rst) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
      irq   <= 1'b0;
    end else begin
      if (match[0]) begin
        out_a <= pin_action(io_sel[0][1:0], out_a);
      end
      if (match[1]) begin
        out_b <= pin_action(io_sel[1][1:0], out_b);
      end
      irq <= |(status & int_mask);
    end
  end

  // Peer outputs lag one cycle behind the local event
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_clear_out   <= 1'b0;
      sync_preset_out  <= 1'b0;
      sync_preset_data <= 16'h0000;
    end else begin
      sync_clear_out  <= local_clear && channel0_sync_select;
      sync_preset_out <= cnt_wr_t3 && !clear_evt
                         && channel0_sync_select;
      if (cnt_wr_t3) begin
        sync_preset_data <= cnt_wr_value;
      end
    end
  end

endmodule // tac_channel

// File: test/tac_channel_props.sv
// Port checks for the timer channel.
// Bound into every tac_channel; one clock, sync reset.
`timescale 1ns/1ns
module tac_channel_props
  import tac_pkg::*;
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst,
  // Register port
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic              bus_wr,
  input wire logic              bus_rd,
  input wire logic [15:0]       bus_rdata,
  // Outputs
  input wire logic              out_a,
  input wire logic              out_b,
  input wire logic              sync_clear_out,
  input wire logic              sync_preset_out,
  input wire logic              irq
);
  logic cnt_wr;
  logic gra_wr;
  logic grb_wr;
  assign cnt_wr = bus_wr && (bus_addr == OFS_COUNT);
  assign gra_wr = bus_wr && (bus_addr == OFS_GR_A);
  assign grb_wr = bus_wr && (bus_addr == OFS_GR_B);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (
    !$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_rd_unmapped: assert property (
    $past(bus_rd) && $past(bus_addr) > OFS_FUNC |-> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_preset_cause: assert property (
    sync_preset_out |-> $past(cnt_wr) || $past(cnt_wr, 2))
    else $error("preset without counter write");
  // Back-to-back counter writes may legally give a two-cycle preset
  a_preset_pulse: assert property (
    sync_preset_out && !$past(cnt_wr) |=> !sync_preset_out)
    else $error("preset pulse without a second write");
  a_clr_over_wr: assert property (
    sync_clear_out |-> !sync_preset_out)
    else $error("preset sent beside a clear");
  // A match in T3 of a compare register write must not move the pin
  a_out_a_muted: assert property (
    $changed(out_a) |-> !$past(gra_wr, 2))
    else $error("output A moved by a suppressed match");
  a_out_b_muted: assert property (
    $changed(out_b) |-> !$past(grb_wr, 2))
    else $error("output B moved by a suppressed match");
  a_reset_quiet: assert property (
    $fell(rst) |-> !irq && !out_a && !out_b && !sync_preset_out)
    else $error("outputs active after reset");
endmodule // tac_channel_props

bind tac_channel tac_channel_props i_props (
  .clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .out_a(out_a), .out_b(out_b),
  .sync_clear_out(sync_clear_out), .sync_preset_out(sync_preset_out),
  .irq(irq));

// File: test/tac_peer.sv
// Peer synchronized channel model.
// Follows presets and clears; raises a clear on request.
`timescale 1ns/1ns
module tac_peer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // From the channel
  input  wire logic        sync_preset_out,
  input  wire logic [15:0] sync_preset_data,
  input  wire logic        sync_clear_out,
  // Bench control
  input  wire logic        clear_req,
  // To the channel and the bench
  output logic             sync_clear_in,
  output logic      [15:0] peer_count
);
  // Unregistered so the bench can place it in one exact cycle
  assign sync_clear_in = clear_req;
  always_ff @(posedge clock) begin
    if (rst) begin
      peer_count <= 16'h0000;
    end else if (sync_clear_out) begin
      peer_count <= 16'h0000;
    end else if (sync_preset_out) begin
      peer_count <= sync_preset_data;
    end
  end
endmodule // tac_peer

// File: test/tb_timer_access_contention.sv
// Bench for the timer channel: register port tasks and scenarios.
// Assumes the channel, its checker and the peer model are compiled.
`timescale 1ns/1ns
module tb_timer_access_contention
  import tac_pkg::*;
;
  logic              clock, rst, bus_wr, bus_rd, cap_a_pin, clear_req;
  logic [3:0]        bus_addr;
  logic [15:0]       bus_wdata, bus_rdata, pd, peer_count;
  logic [1:0]        bus_byte_en;
  logic              out_a, out_b, sc_in, sc_out, sp_out, irq;
  int                bad_count = 0;
  int                total_checks = 0;
  logic [3:0]        ra [6] = '{OFS_COUNT, OFS_GR_A, OFS_GR_B, OFS_BUF_A,
                                OFS_STATUS, 4'hF};
  logic [15:0]       rv [6] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF,
                                16'h0000, 16'h0000};
  tac_channel i_dut (
    .clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_byte_en(bus_byte_en), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .ext_clk_pin(1'b0), .cap_a_pin(cap_a_pin),
    .cap_b_pin(1'b0), .out_a(out_a), .out_b(out_b),
    .sync_clear_in(sc_in), .sync_preset_in(1'b0),
    .sync_preset_value(16'h0000), .sync_clear_out(sc_out),
    .sync_preset_out(sp_out), .sync_preset_data(pd), .irq(irq));
  tac_peer i_peer (
    .clock(clock), .rst(rst), .sync_preset_out(sp_out),
    .sync_preset_data(pd), .sync_clear_out(sc_out), .clear_req(clear_req),
    .sync_clear_in(sc_in), .peer_count(peer_count));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d,
                    input logic [1:0] be = 2'h3);
    @(posedge clock);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    bus_byte_en <= be;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1 cmp(bus_rdata, exp);
  endtask
  function automatic logic pick(input logic b);
    return b ? out_b : out_a;
  endfunction
  // Cycles between two toggles of the chosen compare output
  task automatic period(input logic b, input logic [15:0] exp);
    logic p;
    int n;
    for (int k = 0; k < 2; k++) begin
      p = pick(b);
      n = 0;
      while (pick(b) === p && n < 100) begin
        @(posedge clock);
        #1 n++;
      end
      if (n == 100) begin
        bad_count++;
        wrap_up();
      end
    end
    cmp(16'(n), exp);
  endtask
  initial begin
    {bus_wr, bus_rd, cap_a_pin, clear_req} = 4'h0;
    bus_addr = 4'h0;
    bus_wdata = 16'h0000;
    bus_byte_en = 2'h3;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
    wr(OFS_MODE, 16'h0001);
    wr(OFS_COUNT, 16'h1234);
    rd(OFS_COUNT, 16'h1234);
    wr(OFS_COUNT, 16'h12FE);
    wr(OFS_COUNT, 16'hAB00, 2'h2);
    rd(OFS_COUNT, 16'hABFE);
    wr(OFS_COUNT, 16'hFFFE);
    wr(OFS_COUNT, 16'h0055);
    rd(OFS_COUNT, 16'h0055);
    wr(OFS_MODE, 16'h0000);
    // Write 0 before any read must leave the flag set
    // Both compare flags fire too: a step was due while the count held the GR value
    wr(OFS_STATUS, 16'h0000);
    rd(OFS_STATUS, 16'h0007);
    wr(OFS_MASK, 16'h0004);
    repeat (3) @(posedge clock);
    #1 cmp({15'h0, irq}, 16'h0001);
    wr(OFS_STATUS, 16'h0000);
    rd(OFS_STATUS, 16'h0000);
    repeat (2) @(posedge clock);
    #1 cmp({15'h0, irq}, 16'h0000);
    wr(OFS_GR_A, 16'h0005);
    wr(OFS_IO, 16'h0003);
    wr(OFS_CONTROL, 16'h0020);
    // Start below the compare value, else the first match is far away
    wr(OFS_COUNT, 16'h0000);
    wr(OFS_MODE, 16'h0001);
    period(1'b0, 16'h0006);
    wr(OFS_GR_B, 16'h0003);
    wr(OFS_IO, 16'h0030);
    wr(OFS_CONTROL, 16'h0040);
    wr(OFS_COUNT, 16'h0000);
    wr(OFS_MODE, 16'h0003);
    period(1'b1, 16'h0004);
    // Halted, so the read shows only what the clear left behind
    wr(OFS_MODE, 16'h0002);
    wr(OFS_CONTROL, 16'h0060);
    fork
      wr(OFS_COUNT, 16'h0777);
      begin
        repeat (2) @(posedge clock);
        clear_req <= 1'b1;
        @(posedge clock);
        clear_req <= 1'b0;
      end
    join
    rd(OFS_COUNT, 16'h0000);
    wr(OFS_COUNT, 16'h1234);
    wr(OFS_COUNT, 16'h00CD, 2'h1);
    repeat (3) @(posedge clock);
    #1 cmp(peer_count, 16'h12CD);
    wr(OFS_MODE, 16'h0000);
    wr(OFS_CONTROL, 16'h0000);
    wr(OFS_COUNT, 16'h0042);
    wr(OFS_IO, 16'h0005);
    // Pin edge reaches the capture in T3 of the next write
    cap_a_pin <= 1'b1;
    wr(OFS_GR_A, 16'h1111);
    repeat (2) @(posedge clock);
    rd(OFS_GR_A, 16'h0042);
    wr(OFS_FUNC, 16'h0001);
    wr(OFS_COUNT, 16'h0099);
    wr(OFS_IO, 16'h0007);
    cap_a_pin <= 1'b0;
    wr(OFS_BUF_A, 16'h2222);
    repeat (2) @(posedge clock);
    rd(OFS_BUF_A, 16'h0042);
    rd(OFS_GR_A, 16'h0099);
    // Capture lands in T3 of the first read
    wr(OFS_COUNT, 16'h00AA);
    cap_a_pin <= 1'b1;
    rd(OFS_GR_A, 16'h0099);
    rd(OFS_GR_A, 16'h00AA);
    // Combo bits changed only while halted, via normal mode
    wr(OFS_FUNC, 16'h0020);
    wr(OFS_FUNC, 16'h0000);
    wr(OFS_FUNC, 16'h0030);
    rd(OFS_FUNC, 16'h0030);
    wrap_up();
  end
endmodule // tb_timer_access_contention
